/* rtl/lmpb_consts.vh */
// Constants for the link management parameter bank
`ifndef LMPB_CONSTS_VH
`define LMPB_CONSTS_VH

// Sizes
`define LMPB_NUM_VC            4
`define LMPB_NUM_LANES         2
`define LMPB_VC_NUM_W          2
`define LMPB_PRIO_W            4
`define LMPB_BW_W              7
`define LMPB_SLOT_MAX          256
`define LMPB_SLOT_CNT_W        9
`define LMPB_SLOT_WORDS        8
`define LMPB_LANES_W           3
`define LMPB_RXERR_W           8
`define LMPB_RETRY_W           16
`define LMPB_IDLE_W            20
`define LMPB_BC_SEQ_W          8

// Timing
`define LMPB_CLK_PERIOD_NS     10
`define LMPB_IDLE_TIME_NS      1000000

// Global register byte offsets
`define LMPB_OFF_NUM_SLOTS     11'h000
`define LMPB_OFF_IDLE_LIMIT    11'h004
`define LMPB_OFF_REQ_LANES     11'h008
`define LMPB_OFF_LANE_CTRL     11'h00C
`define LMPB_OFF_STATUS        11'h014
`define LMPB_OFF_RETRY_CNT     11'h018
`define LMPB_OFF_LANE_STAT     11'h01C
`define LMPB_OFF_RXERR         11'h020

// Per-VC block: base + vc*16 + reg*4
`define LMPB_VC_BASE_HI        3'h1
`define LMPB_VC_REG_NUM        2'h0
`define LMPB_VC_REG_PRIO       2'h1
`define LMPB_VC_REG_BW         2'h2
`define LMPB_VC_REG_STAT       2'h3
// Slot bitmaps: 0x400 + vc*32 + word*4

// Lane control and lane status fields
`define LMPB_LANE_HI_POS       8

// Global status bits
`define LMPB_ST_BC_MISSED      0
`define LMPB_ST_BC_SEQ_ERR     1
`define LMPB_ST_CRC16          2
`define LMPB_ST_CRC8_SEQ       3
`define LMPB_ST_RETRY_EMPTY    4
`define LMPB_ST_VCNUM_LOCK     5

// Per-VC status bits
`define LMPB_VS_OVERUSE        0
`define LMPB_VS_UNDERUSE       1
`define LMPB_VS_HAS_CREDIT     2
`define LMPB_VS_OVERFLOW       3

// Cold reset values
`define LMPB_RST_NUM_SLOTS     9'h100
`define LMPB_RST_REQ_LANES     3'h1
`define LMPB_RST_PRIO          4'hF
`define LMPB_RST_BW_VC0        7'h0A
`define LMPB_RST_BW_OTHER      7'h00
`define LMPB_RST_LANE_CTRL     2'h0

`endif

/* rtl/lmpb_param_bank.v */
// Management parameter store: config and status registers behind Avalon-MM
`timescale 1ns/1ns
`include "lmpb_consts.vh"
// Contract
// R1: Config parameters writable and readable.
// R2: Cold reset restores config defaults.
// R3: VC numbers reset to 0..3; writable only after cold reset.
// R4: Priority 0..15 per VC, reset 15.
// R5: Up to 256 slots, reset 256.
// R6: Per-VC slot bitmap, all ones after reset.
// R7: Shared idle limit, default 1 ms.
// R8: Required lane count.
// R9: Lane start mode, reset 0.
// R10: Lane autostart, reset 0.
// R11: Warm and cold reset clear status; W1C otherwise.
// R12: Per-VC overuse flag.
// R13: Underuse when credit maximal for idle limit.
// R14: Per-VC far-end credit indication.
// R15: Per-VC input overflow flag.
// R16: Sequence step of two sets missed flag.
// R17: Step not one or two sets error, first exempt.
// R18: 16-bit checksum failure flag.
// R19: 8-bit checksum or sequence error flag.
// R20: Live retry-buffer-empty status.
// R21: Retry count, plus one per retry.
// R22: Lane active, signal loss flags, error counter.
module lmpb_param_bank #(
    parameter [`LMPB_IDLE_W-1:0] IDLE_CYCLES = `LMPB_IDLE_TIME_NS / `LMPB_CLK_PERIOD_NS
) (
    // Clock and resets
    input  wire                                       ref_clk_in,
    input  wire                                       rst_b_in,
    input  wire                                       cold_reset_in,
    input  wire                                       warm_reset_in,
    // Avalon-MM slave
    input  wire [10:0]                                avs_address_in,
    input  wire                                       avs_read_in,
    input  wire                                       avs_write_in,
    input  wire [31:0]                                avs_writedata_in,
    input  wire [3:0]                                 avs_byteenable_in,
    output reg  [31:0]                                avs_readdata_out,
    output reg                                        avs_waitrequest_out,
    // Virtual channel status sources
    input  wire [`LMPB_NUM_VC-1:0]                    vc_overuse_in,
    input  wire [`LMPB_NUM_VC-1:0]                    vc_credit_max_in,
    input  wire [`LMPB_NUM_VC-1:0]                    vc_has_credit_in,
    input  wire [`LMPB_NUM_VC-1:0]                    vc_overflow_in,
    // Broadcast sequence
    input  wire                                       bc_valid_in,
    input  wire [`LMPB_BC_SEQ_W-1:0]                  bc_seq_in,
    // Quality layer
    input  wire                                       crc16_err_in,
    input  wire                                       crc8_err_in,
    input  wire                                       frame_seq_err_in,
    input  wire                                       retry_empty_in,
    input  wire                                       retry_start_in,
    // Lane layer
    input  wire [`LMPB_NUM_LANES-1:0]                 lane_active_in,
    input  wire [`LMPB_NUM_LANES-1:0]                 signal_loss_in,
    input  wire [`LMPB_NUM_LANES*`LMPB_RXERR_W-1:0]   receive_error_count_in,
    // Configuration outputs and per-VC underuse status
    output reg  [`LMPB_NUM_VC*`LMPB_VC_NUM_W-1:0]     vc_num_out,
    output reg  [`LMPB_NUM_VC*`LMPB_PRIO_W-1:0]       vc_prio_out,
    output reg  [`LMPB_NUM_VC*`LMPB_BW_W-1:0]         vc_bw_out,
    output wire [`LMPB_NUM_VC*`LMPB_SLOT_MAX-1:0]     vc_slots_out,
    output reg  [`LMPB_SLOT_CNT_W-1:0]                num_slots_out,
    output reg  [`LMPB_LANES_W-1:0]                   req_lanes_out,
    output reg  [`LMPB_NUM_LANES-1:0]                 lane_start_out,
    output reg  [`LMPB_NUM_LANES-1:0]                 lane_autostart_out,
    output reg  [`LMPB_NUM_VC-1:0]                    vc_underuse_out
);

    reg  [`LMPB_SLOT_MAX-1:0]   slot_reg [0:`LMPB_NUM_VC-1];
    reg  [`LMPB_IDLE_W-1:0]     idle_limit_reg;
    reg                         vcnum_lock_reg;
    reg  [5:0]                  status_reg;
    reg  [3:0]                  vc_stat_reg [0:`LMPB_NUM_VC-1];
    reg  [`LMPB_RETRY_W-1:0]    retry_cnt_reg;
    reg  [`LMPB_NUM_LANES-1:0]  los_flag_reg;
    reg  [`LMPB_BC_SEQ_W-1:0]   bc_last_reg;
    reg                         bc_first_reg;
    reg  [31:0]                 rdata_next;

    wire                        wr_go;
    wire                        rd_go;
    wire [1:0]                  vc_sel;
    wire [2:0]                  word_sel;
    wire                        vc_hit;
    wire                        slot_hit;
    wire [`LMPB_BC_SEQ_W-1:0]   bc_step;
    wire [`LMPB_NUM_VC-1:0]     underuse_hit;
    wire [31:0]                 nslot_wr;
    wire [31:0]                 idle_wr;

    // Write takes effect only at the edge where waitrequest is seen low
    assign wr_go    = avs_write_in & ~avs_waitrequest_out;
    assign rd_go    = avs_read_in & avs_waitrequest_out;
    assign vc_sel   = avs_address_in[5:4];
    assign word_sel = avs_address_in[4:2];
    assign vc_hit   = (avs_address_in[10:8] == `LMPB_VC_BASE_HI) &&
                      (avs_address_in[7:6] == 2'h0);
    assign slot_hit = avs_address_in[10] && (avs_address_in[9:7] == 3'h0);
    assign bc_step  = bc_seq_in - bc_last_reg;
    assign nslot_wr = lmpb_merge({23'h00_0000, num_slots_out}, avs_writedata_in,
        avs_byteenable_in);
    assign idle_wr  = lmpb_merge({12'h000, idle_limit_reg}, avs_writedata_in,
        avs_byteenable_in);

    function [31:0] lmpb_merge;
        input [31:0] old_val;
        input [31:0] wdata;
        input [3:0]  be;
        integer      k;
        begin
            lmpb_merge = old_val;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    lmpb_merge[8*k +: 8] = wdata[8*k +: 8];
                end
            end
        end
    endfunction

    // One-cycle waitrequest drop per request
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
            if (rd_go) begin
                avs_readdata_out <= rdata_next;
            end
        end
    end

    // Per-VC idle timers
    genvar g;
    generate
        for (g = 0; g < `LMPB_NUM_VC; g = g + 1) begin : g_vc
            reg [`LMPB_IDLE_W-1:0] idle_cnt_reg;
            // R13: credit held at maximum
            assign underuse_hit[g] = vc_credit_max_in[g] && (idle_cnt_reg >= idle_limit_reg);
            always @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    idle_cnt_reg <= {`LMPB_IDLE_W{1'b0}};
                end else if (cold_reset_in || warm_reset_in || !vc_credit_max_in[g]) begin
                    idle_cnt_reg <= {`LMPB_IDLE_W{1'b0}};
                end else if (idle_cnt_reg < idle_limit_reg) begin
                    idle_cnt_reg <= idle_cnt_reg + 1'b1;
                end
            end
            assign vc_slots_out[g*`LMPB_SLOT_MAX +: `LMPB_SLOT_MAX] = slot_reg[g];
        end
    endgenerate

    // Configuration registers
    integer v, u;
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (v = 0; v < `LMPB_NUM_VC; v = v + 1) begin
                // R3: consecutive channel numbers
                vc_num_out[v*`LMPB_VC_NUM_W +: `LMPB_VC_NUM_W] <= v[`LMPB_VC_NUM_W-1:0];
                // R4: priority reset
                vc_prio_out[v*`LMPB_PRIO_W +: `LMPB_PRIO_W]    <= `LMPB_RST_PRIO;
                vc_bw_out[v*`LMPB_BW_W +: `LMPB_BW_W]          <= (v == 0) ?
                    `LMPB_RST_BW_VC0 : `LMPB_RST_BW_OTHER;
                // R6: all slots allowed
                slot_reg[v] <= {`LMPB_SLOT_MAX{1'b1}};
            end
            // R5: full schedule length
            num_slots_out      <= `LMPB_RST_NUM_SLOTS;
            // R7: 1 ms default
            idle_limit_reg     <= IDLE_CYCLES;
            req_lanes_out      <= `LMPB_RST_REQ_LANES;
            lane_start_out     <= `LMPB_RST_LANE_CTRL;
            lane_autostart_out <= `LMPB_RST_LANE_CTRL;
            vcnum_lock_reg     <= 1'b0;
        end else if (cold_reset_in) begin
            // R2: cold reset restores defaults
            for (v = 0; v < `LMPB_NUM_VC; v = v + 1) begin
                vc_num_out[v*`LMPB_VC_NUM_W +: `LMPB_VC_NUM_W] <= v[`LMPB_VC_NUM_W-1:0];
                vc_prio_out[v*`LMPB_PRIO_W +: `LMPB_PRIO_W]    <= `LMPB_RST_PRIO;
                vc_bw_out[v*`LMPB_BW_W +: `LMPB_BW_W]          <= (v == 0) ?
                    `LMPB_RST_BW_VC0 : `LMPB_RST_BW_OTHER;
                slot_reg[v] <= {`LMPB_SLOT_MAX{1'b1}};
            end
            num_slots_out      <= `LMPB_RST_NUM_SLOTS;
            idle_limit_reg     <= IDLE_CYCLES;
            req_lanes_out      <= `LMPB_RST_REQ_LANES;
            lane_start_out     <= `LMPB_RST_LANE_CTRL;
            lane_autostart_out <= `LMPB_RST_LANE_CTRL;
            vcnum_lock_reg     <= 1'b0;
        end else if (wr_go) begin
            // R1: configuration writes
            if (avs_address_in == `LMPB_OFF_NUM_SLOTS) begin
                num_slots_out  <= (nslot_wr > 32'h0000_0100) ? `LMPB_RST_NUM_SLOTS :
                    nslot_wr[`LMPB_SLOT_CNT_W-1:0];
                vcnum_lock_reg <= 1'b1;
            end else if (avs_address_in == `LMPB_OFF_IDLE_LIMIT) begin
                idle_limit_reg <= idle_wr[`LMPB_IDLE_W-1:0];
                vcnum_lock_reg <= 1'b1;
            end else if (avs_address_in == `LMPB_OFF_REQ_LANES) begin
                // R8: required lane count
                if (avs_byteenable_in[0]) begin
                    req_lanes_out <= avs_writedata_in[`LMPB_LANES_W-1:0];
                end
                vcnum_lock_reg <= 1'b1;
            end else if (avs_address_in == `LMPB_OFF_LANE_CTRL) begin
                // R9: lane start mode
                if (avs_byteenable_in[0]) begin
                    lane_start_out <= avs_writedata_in[`LMPB_NUM_LANES-1:0];
                end
                // R10: lane autostart
                if (avs_byteenable_in[1]) begin
                    lane_autostart_out <= avs_writedata_in[`LMPB_LANE_HI_POS +:
                        `LMPB_NUM_LANES];
                end
                vcnum_lock_reg <= 1'b1;
            end else if (vc_hit) begin
                if (avs_address_in[3:2] == `LMPB_VC_REG_NUM) begin
                    // R3: number change only before lock
                    if (!vcnum_lock_reg && avs_byteenable_in[0]) begin
                        vc_num_out[vc_sel*`LMPB_VC_NUM_W +: `LMPB_VC_NUM_W] <=
                            avs_writedata_in[`LMPB_VC_NUM_W-1:0];
                    end
                end else if (avs_address_in[3:2] == `LMPB_VC_REG_PRIO) begin
                    if (avs_byteenable_in[0]) begin
                        vc_prio_out[vc_sel*`LMPB_PRIO_W +: `LMPB_PRIO_W] <=
                            avs_writedata_in[`LMPB_PRIO_W-1:0];
                    end
                    vcnum_lock_reg <= 1'b1;
                end else if (avs_address_in[3:2] == `LMPB_VC_REG_BW) begin
                    if (avs_byteenable_in[0]) begin
                        vc_bw_out[vc_sel*`LMPB_BW_W +: `LMPB_BW_W] <=
                            avs_writedata_in[`LMPB_BW_W-1:0];
                    end
                    vcnum_lock_reg <= 1'b1;
                end
            end else if (slot_hit) begin
                slot_reg[avs_address_in[6:5]][word_sel*32 +: 32] <= lmpb_merge(
                    slot_reg[avs_address_in[6:5]][word_sel*32 +: 32],
                    avs_writedata_in, avs_byteenable_in);
                vcnum_lock_reg <= 1'b1;
            end
        end
    end

    // Status flags; a set in the clearing cycle wins
    always @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_reg      <= 6'h00;
            retry_cnt_reg   <= 16'h0000;
            los_flag_reg    <= 2'h0;
            vc_underuse_out <= 4'h0;
            bc_last_reg     <= 8'h00;
            bc_first_reg    <= 1'b1;
            for (u = 0; u < `LMPB_NUM_VC; u = u + 1) begin
                vc_stat_reg[u] <= 4'h0;
            end
        end else begin
            // R11: warm or cold reset clears status
            if (cold_reset_in || warm_reset_in) begin
                status_reg    <= 6'h00;
                retry_cnt_reg <= 16'h0000;
                los_flag_reg  <= 2'h0;
                for (u = 0; u < `LMPB_NUM_VC; u = u + 1) begin
                    vc_stat_reg[u] <= 4'h0;
                end
            end else begin
                // R11: write-one-to-clear, set wins
                if (wr_go && avs_address_in == `LMPB_OFF_STATUS && avs_byteenable_in[0]) begin
                    status_reg[3:0] <= status_reg[3:0] & ~avs_writedata_in[3:0];
                end
                if (bc_valid_in && !bc_first_reg) begin
                    // R16: sequence skipped by one
                    if (bc_step == 8'h02) begin
                        status_reg[`LMPB_ST_BC_MISSED] <= 1'b1;
                    end
                    // R17: any other step than one or two
                    if (bc_step != 8'h01 && bc_step != 8'h02) begin
                        status_reg[`LMPB_ST_BC_SEQ_ERR] <= 1'b1;
                    end
                end
                // R18: CRC-16 failure
                if (crc16_err_in) begin
                    status_reg[`LMPB_ST_CRC16] <= 1'b1;
                end
                // R19: CRC-8 or frame sequence error
                if (crc8_err_in || frame_seq_err_in) begin
                    status_reg[`LMPB_ST_CRC8_SEQ] <= 1'b1;
                end
                // R21: retry count, any write clears
                if (wr_go && avs_address_in == `LMPB_OFF_RETRY_CNT) begin
                    retry_cnt_reg <= {15'h0000, retry_start_in};
                end else if (retry_start_in) begin
                    retry_cnt_reg <= retry_cnt_reg + 1'b1;
                end
                // R22: signal loss while active
                if (wr_go && avs_address_in == `LMPB_OFF_LANE_STAT && avs_byteenable_in[1]) begin
                    los_flag_reg <= (los_flag_reg & ~avs_writedata_in[9:8]) |
                        (signal_loss_in & lane_active_in);
                end else begin
                    los_flag_reg <= los_flag_reg | (signal_loss_in & lane_active_in);
                end
                for (u = 0; u < `LMPB_NUM_VC; u = u + 1) begin
                    // R12: overuse, R13: underuse, R15: overflow
                    if (wr_go && vc_hit && vc_sel == u[1:0] &&
                        avs_address_in[3:2] == `LMPB_VC_REG_STAT && avs_byteenable_in[0]) begin
                        vc_stat_reg[u] <= (vc_stat_reg[u] & ~avs_writedata_in[3:0]) |
                            {vc_overflow_in[u], 1'b0, underuse_hit[u], vc_overuse_in[u]};
                    end else begin
                        vc_stat_reg[u] <= vc_stat_reg[u] |
                            {vc_overflow_in[u], 1'b0, underuse_hit[u], vc_overuse_in[u]};
                    end
                end
            end
            // R17: first value after cold reset is exempt
            if (cold_reset_in) begin
                bc_last_reg  <= 8'h00;
                bc_first_reg <= 1'b1;
            end else if (bc_valid_in) begin
                bc_last_reg  <= bc_seq_in;
                bc_first_reg <= 1'b0;
            end
            status_reg[`LMPB_ST_RETRY_EMPTY] <= 1'b0;
            status_reg[`LMPB_ST_VCNUM_LOCK]  <= 1'b0;
            for (u = 0; u < `LMPB_NUM_VC; u = u + 1) begin
                vc_underuse_out[u] <= vc_stat_reg[u][`LMPB_VS_UNDERUSE];
            end
        end
    end

    // Read mux
    always @* begin
        rdata_next = 32'h0000_0000;
        if (avs_address_in == `LMPB_OFF_NUM_SLOTS) begin
            rdata_next[`LMPB_SLOT_CNT_W-1:0] = num_slots_out;
        end else if (avs_address_in == `LMPB_OFF_IDLE_LIMIT) begin
            rdata_next[`LMPB_IDLE_W-1:0] = idle_limit_reg;
        end else if (avs_address_in == `LMPB_OFF_REQ_LANES) begin
            rdata_next[`LMPB_LANES_W-1:0] = req_lanes_out;
        end else if (avs_address_in == `LMPB_OFF_LANE_CTRL) begin
            rdata_next[`LMPB_NUM_LANES-1:0] = lane_start_out;
            rdata_next[`LMPB_LANE_HI_POS +: `LMPB_NUM_LANES] = lane_autostart_out;
        end else if (avs_address_in == `LMPB_OFF_STATUS) begin
            rdata_next[3:0] = status_reg[3:0];
            // R20: retry buffer empty, live
            rdata_next[`LMPB_ST_RETRY_EMPTY] = retry_empty_in;
            rdata_next[`LMPB_ST_VCNUM_LOCK]  = vcnum_lock_reg;
        end else if (avs_address_in == `LMPB_OFF_RETRY_CNT) begin
            rdata_next[`LMPB_RETRY_W-1:0] = retry_cnt_reg;
        end else if (avs_address_in == `LMPB_OFF_LANE_STAT) begin
            // R22: lane active and signal loss
            rdata_next[`LMPB_NUM_LANES-1:0] = lane_active_in;
            rdata_next[`LMPB_LANE_HI_POS +: `LMPB_NUM_LANES] = los_flag_reg;
        end else if (avs_address_in == `LMPB_OFF_RXERR) begin
            rdata_next[`LMPB_NUM_LANES*`LMPB_RXERR_W-1:0] = receive_error_count_in;
        end else if (vc_hit) begin
            if (avs_address_in[3:2] == `LMPB_VC_REG_NUM) begin
                rdata_next[`LMPB_VC_NUM_W-1:0] = vc_num_out[vc_sel*`LMPB_VC_NUM_W +:
                    `LMPB_VC_NUM_W];
            end else if (avs_address_in[3:2] == `LMPB_VC_REG_PRIO) begin
                rdata_next[`LMPB_PRIO_W-1:0] = vc_prio_out[vc_sel*`LMPB_PRIO_W +:
                    `LMPB_PRIO_W];
            end else if (avs_address_in[3:2] == `LMPB_VC_REG_BW) begin
                rdata_next[`LMPB_BW_W-1:0] = vc_bw_out[vc_sel*`LMPB_BW_W +: `LMPB_BW_W];
            end else begin
                rdata_next[3:0] = vc_stat_reg[vc_sel];
                // R14: far-end credit, live
                rdata_next[`LMPB_VS_HAS_CREDIT] = vc_has_credit_in[vc_sel];
            end
        end else if (slot_hit) begin
            rdata_next = slot_reg[avs_address_in[6:5]][word_sel*32 +: 32];
        end
    end

endmodule

/* tb/lmpb_param_bank_asserts.sv */
// Port checker for the management parameter bank
`timescale 1ns/1ns
`include "lmpb_consts.vh"
module lmpb_param_bank_asserts (
    // Clock, resets and bus handshake
    input wire logic                                   ref_clk_in,
    input wire logic                                   rst_b_in,
    input wire logic                                   cold_reset_in,
    input wire logic                                   warm_reset_in,
    input wire logic                                   avs_read_in,
    input wire logic                                   avs_write_in,
    input wire logic                                   avs_waitrequest_out,
    // Watched status and configuration
    input wire logic [`LMPB_NUM_VC-1:0]                vc_credit_max_in,
    input wire logic [`LMPB_NUM_VC*`LMPB_VC_NUM_W-1:0] vc_num_out,
    input wire logic [`LMPB_NUM_VC*`LMPB_PRIO_W-1:0]   vc_prio_out,
    input wire logic [`LMPB_NUM_VC*`LMPB_SLOT_MAX-1:0] vc_slots_out,
    input wire logic [`LMPB_SLOT_CNT_W-1:0]            num_slots_out,
    input wire logic [`LMPB_LANES_W-1:0]               req_lanes_out,
    input wire logic [`LMPB_NUM_LANES-1:0]             lane_start_out,
    input wire logic [`LMPB_NUM_LANES-1:0]             lane_autostart_out,
    input wire logic [`LMPB_NUM_VC-1:0]                vc_underuse_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_wait_ans; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no answer");
    property p_wait_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer held too long");
    property p_cold_vcnum; cold_reset_in |=> vc_num_out == 8'he4; endproperty
    a_cold_vcnum: assert property (p_cold_vcnum) else $error("vc numbers");
    property p_cold_prio; cold_reset_in |=> vc_prio_out == 16'hffff; endproperty
    a_cold_prio: assert property (p_cold_prio) else $error("priority");
    property p_cold_slots; cold_reset_in |=> &vc_slots_out; endproperty
    a_cold_slots: assert property (p_cold_slots) else $error("slots");
    property p_cold_cfg;
        cold_reset_in |=> num_slots_out == 9'h100 && req_lanes_out == `LMPB_RST_REQ_LANES
            && lane_start_out == 2'h0 && lane_autostart_out == 2'h0;
    endproperty
    a_cold_cfg: assert property (p_cold_cfg) else $error("config");
    property p_underuse_warm; warm_reset_in |-> ##2 vc_underuse_out == 4'h0; endproperty
    a_underuse_warm: assert property (p_underuse_warm) else $error("underuse kept");
    property p_underuse_rise; $rose(vc_underuse_out[1]) |-> $past(vc_credit_max_in[1], 2); endproperty
    a_underuse_rise: assert property (p_underuse_rise) else $error("stray underuse");
endmodule
bind lmpb_param_bank lmpb_param_bank_asserts u_chk (.*);

/* tb/testbench.sv */
// Self-checking bench for the management parameter bank
`timescale 1ns/1ns
`include "lmpb_consts.vh"
module testbench;
    logic ref_clk_in = 0, rst_b_in = 0, cold_reset_in = 0, warm_reset_in = 0;
    logic avs_read_in = 0, avs_write_in = 0, bc_valid_in = 0, crc16_err_in = 0, crc8_err_in = 0;
    logic frame_seq_err_in = 0, retry_empty_in = 1, retry_start_in = 0, avs_waitrequest_out;
    logic [10:0] avs_address_in = 0;
    logic [31:0] avs_writedata_in = 0, avs_readdata_out, v;
    logic [3:0] vc_overuse_in = 0, vc_credit_max_in = 0, vc_has_credit_in = 0, vc_overflow_in = 0;
    logic [3:0] vc_underuse_out;
    logic [7:0] bc_seq_in = 0;
    logic [1:0] lane_active_in = 0, signal_loss_in = 0, lane_start_out, lane_autostart_out;
    logic [15:0] receive_error_count_in = 0;
    logic [31:0] expq[$];
    logic [10:0] da[12] = '{11'h000, 11'h004, 11'h008, 11'h00c, 11'h104, 11'h108, 11'h118,
        11'h110, 11'h130, 11'h47c, 11'h040, 11'h014};
    logic [31:0] dv[12] = '{32'h0000_0100, 32'h0000_0014, 1, 0, 32'h0000_000f, 32'h0000_000a, 0,
        1, 3, 32'hffff_ffff, 0, 32'h0000_0010};
    logic [2:0] req_lanes_out;
    logic [7:0] vc_num_out;
    integer num_errors = 0, checks = 0, cyc = 0, seed = 32'hd5e9, i;
    lmpb_param_bank #(.IDLE_CYCLES(20'h0_0014)) dut (.ref_clk_in, .rst_b_in, .cold_reset_in,
        .warm_reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in(4'hf), .avs_readdata_out, .avs_waitrequest_out, .vc_overuse_in,
        .vc_credit_max_in, .vc_has_credit_in, .vc_overflow_in, .bc_valid_in, .bc_seq_in,
        .crc16_err_in, .crc8_err_in, .frame_seq_err_in, .retry_empty_in, .retry_start_in,
        .lane_active_in, .signal_loss_in, .receive_error_count_in, .vc_num_out,
        .vc_prio_out(), .vc_bw_out(), .vc_slots_out(), .num_slots_out(), .req_lanes_out,
        .lane_start_out, .lane_autostart_out, .vc_underuse_out);
    initial begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize();
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Held until waitrequest low
    task automatic acc(input logic w, input logic [10:0] a, input logic [31:0] d);
        avs_address_in <= a; avs_write_in <= w; avs_read_in <= !w; avs_writedata_in <= d;
        do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
        avs_read_in <= 0; avs_write_in <= 0;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [10:0] a, input logic [31:0] e);
        expq.push_back(e);
        acc(0, a, 0);
    endtask
    task automatic bc(input logic [7:0] s);
        bc_seq_in <= s; bc_valid_in <= 1; @(posedge ref_clk_in);
        bc_valid_in <= 0; @(posedge ref_clk_in);
    endtask
    always @(posedge ref_clk_in) begin
        if (avs_read_in && avs_waitrequest_out === 1'b0) chk(avs_readdata_out, expq.pop_front());
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_b_in <= 1; @(posedge ref_clk_in);
        for (i = 0; i < 12; i++) rd(da[i], dv[i]);
        acc(1, 11'h100, 3); rd(11'h100, 3); chk(vc_num_out[1:0], 3);
        acc(1, 11'h104, 7); acc(1, 11'h100, 1); rd(11'h100, 3); rd(11'h014, 32'h0000_0030);
        for (i = 0; i < 6; i++) begin
            v = $random(seed);
            acc(1, 11'h400 + {v[4:0], 2'b00}, v); rd(11'h400 + {v[4:0], 2'b00}, v);
        end
        acc(1, 11'h000, 32'h0000_012c); rd(11'h000, 32'h0000_0100);
        acc(1, 11'h000, 5); rd(11'h000, 5); acc(1, 11'h00c, 32'h0000_0201); acc(1, 11'h008, 2);
        chk(lane_start_out, 1); chk(lane_autostart_out, 2); chk(req_lanes_out, 2);
        cold_reset_in <= 1; @(posedge ref_clk_in); cold_reset_in <= 0; @(posedge ref_clk_in);
        rd(11'h104, 32'h0000_000f); rd(11'h000, 32'h0000_0100); rd(11'h014, 32'h0000_0010);
        bc(8'h64); rd(11'h014, 32'h0000_0010); bc(8'h66); rd(11'h014, 32'h0000_0011);
        bc(8'h32); rd(11'h014, 32'h0000_0013);
        {crc16_err_in, crc8_err_in} <= 2'b11; @(posedge ref_clk_in); {crc16_err_in, crc8_err_in} <= 0;
        rd(11'h014, 32'h0000_001f); acc(1, 11'h014, 32'h0000_000f); frame_seq_err_in <= 1;
        @(posedge ref_clk_in); frame_seq_err_in <= 0; rd(11'h014, 32'h0000_0018);
        repeat (3) begin
            retry_start_in <= 1; @(posedge ref_clk_in); retry_start_in <= 0; @(posedge ref_clk_in);
        end
        rd(11'h018, 3);
        {vc_overuse_in, vc_overflow_in, vc_has_credit_in, vc_credit_max_in} <= 16'h2222;
        @(posedge ref_clk_in); {vc_overuse_in, vc_overflow_in} <= 0; repeat (25) @(posedge ref_clk_in);
        rd(11'h11c, 32'h0000_000f); chk(vc_underuse_out, 2);
        v = $random(seed); receive_error_count_in <= v[15:0];
        lane_active_in <= 1; signal_loss_in <= 1; @(posedge ref_clk_in); signal_loss_in <= 0;
        rd(11'h01c, 32'h0000_0101); rd(11'h020, {16'h0000, v[15:0]});
        vc_credit_max_in <= 0; warm_reset_in <= 1; @(posedge ref_clk_in); warm_reset_in <= 0;
        rd(11'h11c, 4); rd(11'h018, 0); rd(11'h014, 32'h0000_0010); rd(11'h01c, 1);
        summarize();
    end
endmodule
